// ==== rtl/fcs_host.sv ====
// Functional notes
// [R1] unlock with AA at first address, then 55 at second, per width
// [R2] single F0 write, optionally after unlock, returns flash to array reads
// [R3] after reset issued during an erase, wait 10 us before trusting reads
// [R4] flash ignores reset during erase and suspension; host refuses it then
// [R5] identification entry is unlock plus 90 at first unlock address
// [R6] ident read with both low address bits low gives manufacturer code
// [R7] ident read with bit one high gives block protection 01 or 00
// [R8] program is unlock, A0 at first address, then target address and data
// [R9] address latched on falling strobe, data on rising strobe
// [R10] after programming starts, reads return poll, toggle and error bits
// [R11] block erase is unlock, 80, unlock, then 30 at a block address
// [R12] extra 30 writes before timeout add blocks and restart the timeout
// [R13] erase timer bit is 0 during timeout and 1 once erasing
// [R14] bad confirm or unlock aborts the erase back to array reads
// [R15] while erasing only suspend is accepted; poll and toggle bits report
// [R16] failed erase sets error bit; host issues reset to clear controller
// [R17] chip erase uses the same sequence with 10 at first unlock address
// [R18] single B0 anywhere suspends a block erase and ends the timeout
// [R19] toggling stops within 0.1 to 15 us after suspend
// [R20] suspended reads of erasing blocks toggle, other blocks give data
// [R21] while suspended only resume and program are accepted
// [R22] single 30 anywhere resumes a suspended erase
// [R23] any invalid sequence returns the flash to array reads
// [R24] flash compares command addresses per width, upper lines ignored
`default_nettype none
module fcs_host #(parameter int ADDR_W = fcs_pkg::ADDR_W) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] flash_dq_out,
   input wire logic [15:0] flash_dq_in,
   output logic flash_dq_drive_n,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_byte_n
);
   import fcs_pkg::*;

   if (ADDR_W < 13 || ADDR_W > 32) begin : g_addr_check
      $error("ADDR_W must lie between 13 and 32");
   end

   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_SETTLE} fcs_st_t;
   typedef struct packed {
      fcs_st_t st;
      fcs_op_t op;
      logic [2:0] idx;
      logic [8:0] cnt;
      logic word_mode;
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [15:0] first_rd;
      logic erase_run;
      logic suspended;
      logic erase_seen;
      logic refused;
      logic toggling;
      logic err_flag;
      logic timer_bit;
      logic req;
      logic bwr;
      logic [ADDR_W-1:0] baddr;
      logic [15:0] bwdata;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fcs_host_t;
   fcs_host_t s, next_s;

   fcs_bus_if #(.ADDR_W(ADDR_W)) bus ();

   // one step of a command sequence: unlock pair, command, user cycle
   function automatic fcs_step_t seq_step(input fcs_op_t op, input logic [2:0] idx);
      fcs_step_t t;
      t = '{last: 1'b1, rd: 1'b0, asel: ADDR_USER, cmd: CMD_RESET, user_data: 1'b0};
      case (op)
         OP_RESET: t.cmd = CMD_RESET;
         OP_ADD_BLOCK: t.cmd = CMD_BLOCK_CONFIRM;
         OP_SUSPEND: t.cmd = CMD_SUSPEND;
         OP_RESUME: t.cmd = CMD_RESUME;
         OP_READ: t.rd = 1'b1;
         OP_POLL: begin
            t.rd = 1'b1;
            t.last = (idx == 3'h1);
         end
         default: begin
            t.last = 1'b0;
            if (op == OP_PROGRAM && idx == 3'h3) begin
               t.user_data = 1'b1;
               t.last = 1'b1;
            end else if (idx == 3'h0 || idx == 3'h3) begin
               t.asel = ADDR_UNLOCK1;
               t.cmd = CMD_UNLOCK1;
            end else if (idx == 3'h1 || idx == 3'h4) begin
               t.asel = ADDR_UNLOCK2;
               t.cmd = CMD_UNLOCK2;
            end else if (idx == 3'h2) begin
               t.asel = ADDR_UNLOCK1;
               t.last = (op == OP_RESET_UNLOCK || op == OP_IDENT);
               case (op)
                  OP_RESET_UNLOCK: t.cmd = CMD_RESET;
                  OP_IDENT: t.cmd = CMD_IDENT;
                  OP_PROGRAM: t.cmd = CMD_PROGRAM;
                  default: t.cmd = CMD_SETUP_ERASE;
               endcase
            end else begin
               t.last = 1'b1;
               t.cmd = (op == OP_CHIP_ERASE) ? CMD_CHIP_CONFIRM : CMD_BLOCK_CONFIRM;
               t.asel = (op == OP_CHIP_ERASE) ? ADDR_UNLOCK1 : ADDR_USER;
            end
         end
      endcase
      return t;
   endfunction

   // unlock address by organisation, user address otherwise
   function automatic logic [ADDR_W-1:0] step_addr(input fcs_asel_t a, input logic word,
                                                   input logic [ADDR_W-1:0] user);
      case (a)
         ADDR_UNLOCK1: return ADDR_W'(word ? UNLOCK1_WORD : UNLOCK1_BYTE);
         ADDR_UNLOCK2: return ADDR_W'(word ? UNLOCK2_WORD : UNLOCK2_BYTE);
         default: return user;
      endcase
   endfunction

   // apb slave, command acceptance and sequence stepping
   always_comb begin
      logic issue;
      logic ok;
      logic apb_wr;
      fcs_step_t cur;
      fcs_step_t nst;
      fcs_op_t req_op;
      issue = 1'b0;
      ok = 1'b0;
      apb_wr = psel && penable && s.pready && pwrite;
      cur = seq_step(s.op, s.idx);
      nst = cur;
      req_op = fcs_op_t'(pwdata[3:0]);
      next_s = s;
      next_s.pready = psel && !penable;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (psel && !penable) begin
         case (paddr)
            REG_CTRL: next_s.prdata = {28'h0000000, s.op};
            REG_ADDR: next_s.prdata = 32'(s.addr);
            REG_WDATA: next_s.prdata = {16'h0000, s.wdata};
            REG_CFG: next_s.prdata = {31'h00000000, s.word_mode};
            REG_STATUS: next_s.prdata = {25'h0000000, s.timer_bit, s.err_flag, s.toggling,
                                         s.refused, s.suspended, s.erase_run,
                                         s.st != S_IDLE};
            REG_RDATA: next_s.prdata = {16'h0000, s.rdata};
            default: next_s.pslverr = 1'b1;
         endcase
      end
      if (apb_wr) begin
         case (paddr)
            REG_ADDR: next_s.addr = pwdata[ADDR_W-1:0];
            REG_WDATA: next_s.wdata = pwdata[15:0];
            REG_CFG: next_s.word_mode = pwdata[0];
            REG_STATUS: if (pwdata[ST_REFUSED]) next_s.refused = 1'b0;
            default: ;
         endcase
      end
      // [R4] [R21] reset and erase refused during suspension
      // [R15] during erase only suspend, extra blocks and status reads
      if (s.suspended) begin
         ok = req_op inside {OP_RESUME, OP_PROGRAM, OP_READ, OP_POLL};
      end else if (s.erase_run) begin
         ok = req_op inside {OP_SUSPEND, OP_ADD_BLOCK, OP_READ, OP_POLL};
      end else begin
         ok = pwdata[3:0] <= 4'(OP_POLL) && req_op != OP_RESUME;
      end
      if (apb_wr && paddr == REG_CTRL) begin
         if (s.st != S_IDLE || !ok) begin
            next_s.refused = 1'b1;
         end else begin
            next_s.op = req_op;
            next_s.idx = 3'h0;
            next_s.st = S_ISSUE;
            issue = 1'b1;
         end
      end
      case (s.st)
         S_IDLE: ;
         S_ISSUE: begin
            if (s.req && bus.ack) begin
               next_s.req = 1'b0;
               if (s.op == OP_POLL && s.idx == 3'h0) next_s.first_rd = bus.rdata;
               if (cur.rd) next_s.rdata = bus.rdata;
               if (!cur.last) begin
                  next_s.idx = s.idx + 3'h1;
                  issue = 1'b1;
               end else begin
                  next_s.st = S_IDLE;
                  case (s.op)
                     // [R3] [R16] settle after reset that follows an erase
                     OP_RESET, OP_RESET_UNLOCK: begin
                        next_s.err_flag = 1'b0;
                        if (s.erase_seen) begin
                           next_s.erase_seen = 1'b0;
                           next_s.cnt = 9'(RESET_WAIT_CYC - 1);
                           next_s.st = S_SETTLE;
                        end
                     end
                     // [R12] [R22] erase starts or resumes
                     OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_RESUME, OP_ADD_BLOCK: begin
                        next_s.erase_run = 1'b1;
                        next_s.erase_seen = 1'b1;
                        next_s.suspended = 1'b0;
                     end
                     // [R18] [R19] suspend, then wait for toggling to stop
                     OP_SUSPEND: begin
                        next_s.suspended = 1'b1;
                        next_s.erase_run = 1'b0;
                        next_s.cnt = 9'(SUSPEND_WAIT_CYC - 1);
                        next_s.st = S_SETTLE;
                     end
                     // [R10] [R13] [R16] two reads decide toggle, error, timer
                     OP_POLL: begin
                        next_s.toggling = s.first_rd[TOGGLE_BIT] ^ bus.rdata[TOGGLE_BIT];
                        next_s.err_flag = bus.rdata[ERROR_FLAG_BIT];
                        next_s.timer_bit = bus.rdata[ERASE_TIMER_BIT];
                        if (s.first_rd[TOGGLE_BIT] == bus.rdata[TOGGLE_BIT]) begin
                           next_s.erase_run = 1'b0;
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         S_SETTLE: begin
            if (s.cnt == 9'h000) next_s.st = S_IDLE;
            else next_s.cnt = s.cnt - 9'h001;
         end
         default: next_s.st = S_IDLE;
      endcase
      // [R1] [R2] [R5] [R8] [R11] [R17] load the next flash cycle
      if (issue) begin
         nst = seq_step(next_s.op, next_s.idx);
         next_s.req = 1'b1;
         next_s.bwr = !nst.rd;
         next_s.baddr = step_addr(nst.asel, s.word_mode, next_s.addr);
         next_s.bwdata = nst.user_data ? next_s.wdata : {8'h00, nst.cmd};
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.word_mode <= CFG_WORD_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign bus.req = s.req;
   assign bus.wr = s.bwr;
   assign bus.addr = s.baddr;
   assign bus.wdata = s.bwdata;
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign flash_byte_n = s.word_mode;

   fcs_cycle_engine #(.ADDR_W(ADDR_W)) u_engine (
      .pclk(pclk),
      .presetn(presetn),
      .bus(bus),
      .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in),
      .flash_dq_drive_n(flash_dq_drive_n),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n)
   );

   // command cycle checks
   a_unlock_first: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      $rose(bus.req) && s.idx == 3'h0 && s.op inside {[OP_RESET_UNLOCK:OP_CHIP_ERASE]}
      |-> bus.wdata == 16'h00aa && bus.addr[11:0] == (s.word_mode ? 12'h555 : 12'haaa))
      else $error("first unlock cycle wrong");
   a_unlock_second: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      bus.req && s.idx == 3'h1 && s.op inside {[OP_RESET_UNLOCK:OP_CHIP_ERASE]}
      |-> bus.wdata == 16'h0055 && bus.addr[11:0] == (s.word_mode ? 12'h2aa : 12'h555))
      else $error("second unlock cycle wrong");
   a_reset_single: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      bus.req && s.op == OP_RESET |-> bus.wr && bus.wdata == 16'h00f0 && s.idx == 3'h0)
      else $error("reset command wrong");
   a_ident_cmd: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      bus.req && s.op == OP_IDENT && s.idx == 3'h2 |-> bus.wdata == 16'h0090)
      else $error("ident command wrong");
   a_program_cmd: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      bus.req && s.op == OP_PROGRAM && s.idx == 3'h3 |-> bus.wdata == s.wdata
      && bus.addr == s.addr && $past(s.idx) inside {3'h2, 3'h3})
      else $error("program data cycle wrong");
   a_block_confirm: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      bus.req && s.op == OP_BLOCK_ERASE && s.idx == 3'h5 |-> bus.wdata == 16'h0030
      && bus.addr == s.addr)
      else $error("block erase confirm wrong");
   a_chip_confirm: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      bus.req && s.op == OP_CHIP_ERASE && s.idx == 3'h5 |-> bus.wdata == 16'h0010)
      else $error("chip erase confirm wrong");
   a_suspend_cmd: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      s.st == S_ISSUE && s.op == OP_SUSPEND && bus.ack |=> s.st == S_SETTLE
      && s.cnt == 9'h12b && s.suspended)
      else $error("suspend wait not started");
   a_reset_settle: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      s.st == S_SETTLE && s.cnt != 9'h000 |=> s.st == S_SETTLE && s.cnt == $past(s.cnt) - 9'h001)
      else $error("settle wait cut short");
   a_refuse_susp: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[3:0] == 4'h0
      && s.suspended |=> s.refused && s.st == $past(s.st))
      else $error("reset accepted while suspended");
   cp_program: cover property (@(posedge pclk) disable iff (!presetn)
      s.op == OP_PROGRAM && s.idx == 3'h3 && bus.ack);
   cp_block_erase: cover property (@(posedge pclk) disable iff (!presetn)
      s.op == OP_BLOCK_ERASE && s.idx == 3'h5 && bus.ack);
   cp_suspend: cover property (@(posedge pclk) disable iff (!presetn)
      s.op == OP_SUSPEND && s.st == S_SETTLE);
   cp_poll_toggle: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(s.toggling));
endmodule
`default_nettype wire

// ==== pkg/fcs_pkg.sv ====
`default_nettype none
package fcs_pkg;
   // flash pin widths
   localparam int ADDR_W = 20;
   localparam int DQ_W = 16;
   // command codes written on the low data byte
   localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_SETUP_ERASE = 8'h80;
   localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   // unlock addresses for byte-wide and word-wide organisation
   localparam logic [11:0] UNLOCK1_BYTE = 12'haaa;
   localparam logic [11:0] UNLOCK1_WORD = 12'h555;
   localparam logic [11:0] UNLOCK2_BYTE = 12'h555;
   localparam logic [11:0] UNLOCK2_WORD = 12'h2aa;
   // timing, clock is 20 MHz
   localparam int CLK_NS = 50;
   localparam int RESET_WAIT_NS = 10000;
   localparam int SUSPEND_WAIT_NS = 15000;
   localparam int WE_LOW_NS = 100;
   localparam int ACCESS_NS = 100;
   localparam int RESET_WAIT_CYC = (RESET_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUSPEND_WAIT_CYC = (SUSPEND_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   localparam logic CFG_WORD_RESET = 1'b1;
   // status register bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_ERASE_RUN = 1;
   localparam int ST_SUSPENDED = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_TOGGLING = 4;
   localparam int ST_ERROR = 5;
   localparam int ST_TIMER = 6;
   // flash status bits on the data lines
   localparam int DATA_POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int ERROR_FLAG_BIT = 5;
   localparam int ERASE_TIMER_BIT = 3;
   localparam int ALT_TOGGLE_BIT = 2;
   // operations software can start
   typedef enum logic [3:0] {
      OP_RESET, OP_RESET_UNLOCK, OP_IDENT, OP_PROGRAM, OP_BLOCK_ERASE, OP_CHIP_ERASE,
      OP_ADD_BLOCK, OP_SUSPEND, OP_RESUME, OP_READ, OP_POLL
   } fcs_op_t;
   typedef enum logic [1:0] {ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_USER} fcs_asel_t;
   typedef struct packed {
      logic last;
      logic rd;
      fcs_asel_t asel;
      logic [7:0] cmd;
      logic user_data;
   } fcs_step_t;
endpackage
`default_nettype wire

// ==== pkg/fcs_bus_if.sv ====
`default_nettype none
interface fcs_bus_if #(parameter int ADDR_W = 20) ();
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport engine(input req, wr, addr, wdata, output ack, rdata);
   modport seq(output req, wr, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// ==== rtl/fcs_cycle_engine.sv ====
`default_nettype none
module fcs_cycle_engine #(parameter int ADDR_W = fcs_pkg::ADDR_W) (
   input wire logic pclk,
   input wire logic presetn,
   fcs_bus_if.engine bus,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] flash_dq_out,
   input wire logic [15:0] flash_dq_in,
   output logic flash_dq_drive_n,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n
);
   import fcs_pkg::*;
   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOVER} fcs_est_t;
   typedef struct packed {
      fcs_est_t st;
      logic [2:0] cnt;
      logic wr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic drive_n;
      logic [ADDR_W-1:0] addr;
      logic [15:0] dout;
      logic ack;
      logic [15:0] rdata;
   } fcs_eng_t;
   fcs_eng_t s, next_s;

   // one bus cycle per request, address and data held for the whole strobe
   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      case (s.st)
         E_IDLE: begin
            if (bus.req && !s.ack) begin
               next_s.wr = bus.wr;
               next_s.addr = bus.addr;
               next_s.dout = bus.wdata;
               next_s.ce_n = 1'b0;
               next_s.drive_n = !bus.wr;
               next_s.oe_n = bus.wr;
               next_s.st = E_SETUP;
            end
         end
         E_SETUP: begin
            next_s.we_n = !s.wr;
            next_s.cnt = s.wr ? 3'(WE_LOW_CYC - 1) : 3'(ACCESS_CYC - 1);
            next_s.st = E_STROBE;
         end
         E_STROBE: begin
            if (s.cnt != 3'h0) begin
               next_s.cnt = s.cnt - 3'h1;
            end else if (s.wr) begin
               next_s.we_n = 1'b1;
               next_s.st = E_RECOVER;
            end else begin
               next_s.rdata = flash_dq_in;
               next_s.oe_n = 1'b1;
               next_s.ce_n = 1'b1;
               next_s.ack = 1'b1;
               next_s.st = E_IDLE;
            end
         end
         E_RECOVER: begin
            next_s.ce_n = 1'b1;
            next_s.drive_n = 1'b1;
            next_s.ack = 1'b1;
            next_s.st = E_IDLE;
         end
         default: next_s.st = E_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{st: E_IDLE, cnt: 3'h0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                drive_n: 1'b1, addr: '0, dout: 16'h0000, ack: 1'b0, rdata: 16'h0000};
      end else begin
         s <= next_s;
      end
   end

   assign flash_addr = s.addr;
   assign flash_dq_out = s.dout;
   assign flash_dq_drive_n = s.drive_n;
   assign flash_ce_n = s.ce_n;
   assign flash_oe_n = s.oe_n;
   assign flash_we_n = s.we_n;
   assign bus.ack = s.ack;
   assign bus.rdata = s.rdata;

   // address steady under the strobe, data stays driven past its rising edge
   a_we_pulse_len: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      $fell(flash_we_n) |-> !flash_we_n [*2] ##1 (flash_we_n && !flash_dq_drive_n))
      else $error("write strobe width or data hold wrong");
   a_addr_stable_we: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      !flash_we_n |-> $stable(flash_addr) && !flash_ce_n && !flash_dq_drive_n)
      else $error("address or data moved under write strobe");
   a_read_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
      !flash_oe_n |-> flash_dq_drive_n && flash_we_n)
      else $error("data driven during read");
   cp_write_cycle: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(flash_we_n) ##1 bus.ack);
endmodule
`default_nettype wire

// ==== bench/fcs_flash_model.sv ====
`default_nettype none
// behavioural flash, word-wide; the id codes are arbitrary values
module fcs_flash_model #(parameter logic [7:0] MFR = 8'h3c, parameter logic [7:0] DEV = 8'h4d) (
   input wire logic [19:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_drive_n,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   output logic [15:0] flash_dq_in
);
   logic [15:0] mem [int];
   logic [7:0] h [0:5];
   logic [11:0] ha [0:5];
   logic [19:0] la;
   logic [15:0] q = 16'h0;
   logic tg = 1'b0;
   int mode = 0; // 0 array, 1 ident, 2 program data, 3 erasing, 4 suspended
   always @(negedge flash_we_n) la = flash_addr;
   // unlock pair on the low address lines
   function automatic bit unl(int i);
      return h[i] == 8'haa && ha[i] == 12'h555 && h[i+1] == 8'h55 && ha[i+1] == 12'h2aa;
   endfunction
   // data taken on rising strobe, then the command decode
   always @(posedge flash_we_n) begin
      for (int i = 0; i < 5; i++) begin
         h[i] = h[i+1];
         ha[i] = ha[i+1];
      end
      h[5] = flash_dq_out[7:0];
      ha[5] = la[11:0];
      // erase and suspend honour only suspend and resume
      if (mode == 2) begin
         mem[la] = flash_dq_out;
         mode = 0;
      end else if (mode == 3) mode = (h[5] == 8'hb0) ? 4 : 3;
      else if (mode == 4) mode = (h[5] == 8'h30) ? 3 : 4;
      else if (unl(3) && ha[5] == 12'h555 && h[5] == 8'h90) mode = 1;
      else if (unl(3) && ha[5] == 12'h555 && h[5] == 8'ha0) mode = 2;
      else if (unl(0) && h[2] == 8'h80 && unl(3) && h[5] == 8'h30) mode = 3;
      else if (unl(0) && h[2] == 8'h80 && unl(3) && h[5] == 8'h10) mode = 3;
      // anything else falls back to array reads
      else mode = 0;
   end
   always @(negedge flash_oe_n) begin
      tg = ~tg;
      case (mode)
         1: q = flash_addr[1] ? {15'h0, flash_addr[12]} : {8'h0, flash_addr[0] ? DEV : MFR};
         3: q = {8'h0, 1'b0, tg, 3'b001, tg, 2'b00};
         default: q = mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff;
      endcase
   end
   // released lines show the inverse of the last value
   assign flash_dq_in = !flash_dq_drive_n ? flash_dq_out : (!flash_oe_n ? q : ~q);
endmodule
`default_nettype wire

// ==== bench/fcs_host_tb.sv ====
`default_nettype none
module fcs_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fcs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [19:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in;
   logic flash_dq_drive_n, flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n;
   int errors = 0, checks = 0;
   fcs_host fcs_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_in, .flash_dq_drive_n,
      .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n);
   fcs_flash_model fcs_flash_model_i (.flash_addr, .flash_dq_out, .flash_dq_in,
      .flash_dq_drive_n, .flash_ce_n, .flash_oe_n, .flash_we_n);
   initial forever #25 pclk = ~pclk;
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // start an operation and wait for busy to fall
   task automatic op(logic [3:0] c);
      int n = 0;
      apb(1'b1, REG_CTRL, {28'h0, c});
      do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0 && ++n < 400);
      if (rd[ST_BUSY] !== 1'b0) errors++;
   endtask
   task automatic rdfl(logic [31:0] a);
      apb(1'b1, REG_ADDR, a);
      op(4'h9);
      apb(1'b0, REG_RDATA, 32'h0);
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_CFG, 32'h0);
      chk("cfg", rd, 32'h1);
      chk("byte_n", {31'h0, flash_byte_n}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      op(4'h2);
      rdfl(32'h0);
      chk("mfr", rd[7:0], 8'h3c);
      rdfl(32'h1);
      chk("dev", rd[7:0], 8'h4d);
      rdfl(32'h2);
      chk("open", rd[7:0], 8'h00);
      rdfl(32'h1002);
      chk("prot", rd[7:0], 8'h01);
      apb(1'b1, REG_WDATA, 32'hbeef);
      apb(1'b1, REG_ADDR, 32'h1234);
      op(4'h3);
      op(4'h0);
      rdfl(32'h1234);
      chk("prog", rd[15:0], 16'hbeef);
      op(4'h2);
      op(4'h1);
      rdfl(32'h1234);
      chk("reset", rd[15:0], 16'hbeef);
      apb(1'b1, REG_ADDR, 32'h30000);
      op(4'h4);
      op(4'ha);
      chk("erase", rd[6:1], 6'b101001);
      op(4'h0);
      chk("refuse", rd[ST_REFUSED], 1'b1);
      apb(1'b1, REG_STATUS, 32'h8);
      op(4'h7);
      chk("susp", rd[ST_SUSPENDED], 1'b1);
      op(4'h0);
      chk("refuse susp", rd[ST_REFUSED], 1'b1);
      apb(1'b1, REG_STATUS, 32'h8);
      op(4'h8);
      chk("resume", rd[3:1], 3'b001);
      op(4'h6);
      chk("add", rd[3:1], 3'b001);
      op(4'ha);
      chk("erase again", rd[6:1], 6'b101001);
      stop_test();
   end
endmodule
`default_nettype wire
